/* File: rtl/sbat_arbiter.sv */
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// Functional notes
// - Nine-bit up-counter with overflow bit.
// - Mode field: idle, measure, arbitrate, reserved.
// - Lost flag cleared by writing zero high.
// - Clock: half prescaler or bus quarter.
// - Finished flag set; any control write clears.
// - Running flag shows counter counting.
// - Overflow flag set; control write clears.
// - Idle mode holds counter cleared.
// - Counter readable; control write clears it.
// - Select zero: falling edge to falling edge.
// - Select one: start while receive low.
// - Select one: stop on rising edge.
// - Arbitration restarts on transmit rising edge.
// - Sample receive at 0x38 or 0x08.
// - Lost flag forces transmit pin high.
// - Transmit low first: reset, await rise.
// - Baud source bus or quad clock.
// - Baud is source over divider chain.
module sbat_arbiter
  import sbat_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       quad_tick,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       rx_pin,
  input  wire logic       tx_shift_out,
  output logic            tx_pin,
  output logic            baud_tick,
  output logic            irq
);

  sbat_req_t   req;
  sbat_state_t state;
  logic [1:0]  arb_mode_sel;
  logic        clk_sel;
  logic [SBAT_CNT_W-1:0] count;
  logic        arb_lost_flag;
  logic        measure_done_flag;
  logic        counter_overflow_flag;
  logic [7:0]  baud_cfg;
  logic [7:0]  pre_cfg;
  logic [2:0]  irq_status;
  logic [2:0]  irq_enable;
  logic [1:0]  quarter_cnt;
  logic        bus_tick;
  logic        pre_tick;
  logic        half_tog;
  logic        cnt_tick;
  logic        rx_sync;
  logic        rx_prev;
  logic        tx_prev;
  logic        rx_fall;
  logic        rx_rise;
  logic        tx_rise;
  logic        ctrl_wr;
  logic        ev_lost;
  logic        ev_fin;
  logic        ev_ovf;
  logic        sample_hit;
  logic        baud_raw;
  logic        counter_running_flag;

  assign req     = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign ctrl_wr = req.wr && (req.addr == {1'b0, SBAT_ADDR_CTRL});

  function automatic logic is_mode(input logic [1:0] m, input sbat_mode_t want);
    return m == 2'(want);
  endfunction

  sbat_rx_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rx_pin  (rx_pin),
    .rx_sync (rx_sync)
  );

  sbat_baud_gen u_baud (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .quad_tick            (quad_tick),
    .bus_tick             (1'b1),
    .baud_source_sel      (baud_cfg[SBAT_BIT_SRC]),
    .reg_prescale_div     (baud_cfg[4:3]),
    .baud_divisor         (baud_cfg[2:0]),
    .prescale_divisor     (pre_cfg[7:5]),
    .prescale_fine_adjust (pre_cfg[4:0]),
    .pre_tick             (pre_tick),
    .baud_tick            (baud_raw)
  );

  // Bus clock quarter and half of prescaler output as enable pulses.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      quarter_cnt <= 2'h0;
      half_tog    <= 1'b0;
    end else begin
      quarter_cnt <= quarter_cnt + 2'h1;
      if (pre_tick) half_tog <= ~half_tog;
    end
  end
  assign bus_tick = (quarter_cnt == SBAT_QUARTER);
  assign cnt_tick = clk_sel ? (pre_tick && half_tog) : bus_tick;

  // Edge detectors on the synchronised receive and on transmit shift output.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_prev <= 1'b1;
      tx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_sync;
      tx_prev <= tx_shift_out;
    end
  end
  assign rx_fall = rx_prev && !rx_sync;
  assign rx_rise = !rx_prev && rx_sync;
  assign tx_rise = !tx_prev && tx_shift_out;

  // Software-written fields; writing the mode also touches the lost flag.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arb_mode_sel <= 2'h0;
      clk_sel      <= 1'b0;
      baud_cfg     <= SBAT_RST_BYTE;
      pre_cfg      <= SBAT_RST_BYTE;
      irq_enable   <= 3'h0;
    end else if (req.wr) begin
      case (req.addr)
        {1'b0, SBAT_ADDR_CTRL}: begin
          arb_mode_sel <= req.wdata[SBAT_BIT_AM_HI:SBAT_BIT_AM_LO];
          clk_sel      <= req.wdata[SBAT_BIT_CLKS];
        end
        {1'b0, SBAT_ADDR_BAUD}: baud_cfg <= req.wdata;
        {1'b0, SBAT_ADDR_PRE}:  pre_cfg <= req.wdata;
        SBAT_ADDR_IRQEN:        irq_enable <= req.wdata[2:0];
        default: ;
      endcase
    end
  end

  assign sample_hit = (count == (clk_sel ? SBAT_SAMPLE_P : SBAT_SAMPLE_Q));

  // Counter state machine; mode zero and any control write clear the count.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SBAT_ST_WAIT;
      count <= 9'h000;
      ev_fin <= 1'b0;
      ev_ovf <= 1'b0;
      ev_lost <= 1'b0;
    end else begin
      ev_fin  <= 1'b0;
      ev_ovf  <= 1'b0;
      ev_lost <= 1'b0;
      if (ctrl_wr || is_mode(arb_mode_sel, SBAT_MODE_IDLE) ||
          is_mode(arb_mode_sel, SBAT_MODE_RSVD)) begin
        state <= SBAT_ST_WAIT;
        count <= 9'h000;
      end else if (is_mode(arb_mode_sel, SBAT_MODE_MEAS)) begin
        case (state)
          SBAT_ST_WAIT: begin
            if (clk_sel ? !rx_sync : rx_fall) state <= SBAT_ST_RUN;
          end
          SBAT_ST_RUN: begin
            if (clk_sel ? rx_rise : rx_fall) begin
              state  <= SBAT_ST_STOP;
              ev_fin <= 1'b1;
            end else if (cnt_tick) begin
              count <= count + 9'h001;
              if (&count) ev_ovf <= 1'b1;
            end
          end
          SBAT_ST_STOP: ;
          default: state <= SBAT_ST_WAIT;
        endcase
      end else begin
        // Arbitration: the sample is taken when the count since the last transmit rising edge reaches the sample point.
        case (state)
          SBAT_ST_WAIT: begin
            if (tx_rise) begin
              state <= SBAT_ST_RUN;
              count <= 9'h000;
            end
          end
          SBAT_ST_RUN: begin
            if (tx_rise) begin
              count <= 9'h000;
            end else if (!tx_shift_out) begin
              state <= SBAT_ST_WAIT;
              count <= 9'h000;
            end else if (cnt_tick) begin
              if (sample_hit && !rx_sync) ev_lost <= 1'b1;
              count <= count + 9'h001;
              if (&count) ev_ovf <= 1'b1;
            end
          end
          default: state <= SBAT_ST_WAIT;
        endcase
      end
    end
  end

  assign counter_running_flag = (state == SBAT_ST_RUN) && !is_mode(arb_mode_sel, SBAT_MODE_IDLE);

  // Sticky flags: a same-cycle event beats the clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arb_lost_flag         <= 1'b0;
      measure_done_flag     <= 1'b0;
      counter_overflow_flag <= 1'b0;
    end else begin
      if (ev_lost) arb_lost_flag <= 1'b1;
      else if (ctrl_wr && !req.wdata[SBAT_BIT_AM_HI]) arb_lost_flag <= 1'b0;
      if (ev_fin) measure_done_flag <= 1'b1;
      else if (ctrl_wr) measure_done_flag <= 1'b0;
      if (ev_ovf) counter_overflow_flag <= 1'b1;
      else if (ctrl_wr) counter_overflow_flag <= 1'b0;
    end
  end

  // Interrupt status: set wins over the write-one clear.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~((req.wr && req.addr == SBAT_ADDR_IRQCL) ?
                     req.wdata[2:0] : 3'h0)) | {ev_ovf, ev_fin, ev_lost};
    end
  end

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_pin    <= 1'b1;
      irq       <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      tx_pin    <= tx_shift_out | arb_lost_flag | ev_lost;
      irq       <= |(irq_status & irq_enable);
      baud_tick <= baud_raw;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        {1'b0, SBAT_ADDR_CTRL}: reg_rdata <= {count[8], counter_overflow_flag,
                                counter_running_flag, measure_done_flag, clk_sel,
                                arb_lost_flag, arb_mode_sel};
        {1'b0, SBAT_ADDR_DATA}: reg_rdata <= count[7:0];
        {1'b0, SBAT_ADDR_BAUD}: reg_rdata <= baud_cfg;
        {1'b0, SBAT_ADDR_PRE}:  reg_rdata <= pre_cfg;
        SBAT_ADDR_IRQST:        reg_rdata <= {5'h00, irq_status};
        SBAT_ADDR_IRQEN:        reg_rdata <= {5'h00, irq_enable};
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks.
  property p_lost_forces_tx;
    @(posedge clk) disable iff (sys_rst) arb_lost_flag |=> tx_pin;
  endproperty
  a_lost_forces_tx: assert property (p_lost_forces_tx) else $error("tx not forced");

  property p_ctrl_wr_clears;
    @(posedge clk) disable iff (sys_rst) ctrl_wr |=> (count == 9'h000);
  endproperty
  a_ctrl_wr_clears: assert property (p_ctrl_wr_clears) else $error("count not cleared");

  property p_idle_holds;
    @(posedge clk) disable iff (sys_rst)
      (arb_mode_sel == 2'h0) ##1 (arb_mode_sel == 2'h0) |-> (count == 9'h000) && !counter_running_flag;
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("idle counting");

  property p_fin_sets;
    @(posedge clk) disable iff (sys_rst) ev_fin |=> measure_done_flag;
  endproperty
  a_fin_sets: assert property (p_fin_sets) else $error("finish lost");

  property p_ovf_sets;
    @(posedge clk) disable iff (sys_rst) ev_ovf |=> counter_overflow_flag;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("overflow lost");

  property p_count_step;
    @(posedge clk) disable iff (sys_rst)
      (state == SBAT_ST_RUN) && cnt_tick && !ctrl_wr && (arb_mode_sel == 2'h1) &&
      !(clk_sel ? rx_rise : rx_fall) |=> count == $past(count) + 9'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count stalled");

  property p_lost_cause;
    @(posedge clk) disable iff (sys_rst) $rose(arb_lost_flag) |-> $past(ev_lost);
  endproperty
  a_lost_cause: assert property (p_lost_cause) else $error("spurious lost");

  property p_quarter;
    @(posedge clk) disable iff (sys_rst) bus_tick |=> !bus_tick [*3] ##1 bus_tick;
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter rate wrong");

endmodule

/* File: rtl/sbat_baud_gen.sv */
`timescale 1ns/100ps
module sbat_baud_gen
  import sbat_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       quad_tick,
  input  wire logic       bus_tick,
  input  wire logic       baud_source_sel,
  input  wire logic [1:0] reg_prescale_div,
  input  wire logic [2:0] baud_divisor,
  input  wire logic [2:0] prescale_divisor,
  input  wire logic [4:0] prescale_fine_adjust,
  output logic            pre_tick,
  output logic            baud_tick
);

  logic [3:0]  pd_cnt;
  logic [4:0]  frame;
  logic        insert;
  logic [5:0]  os_cnt;
  logic [3:0]  bpd_cnt;
  logic [7:0]  bd_cnt;
  logic        src_tick;
  logic [3:0]  bpd_max;
  logic        pd_done;
  logic        os_tick;
  logic        bpd_tick;

  // Source clock choice.
  assign src_tick = baud_source_sel ? quad_tick : bus_tick;

  // Register prescaler divisor decode: 1, 3, 4 or 13.
  always_comb begin
    case (reg_prescale_div)
      2'h0:    bpd_max = 4'h0;
      2'h1:    bpd_max = 4'h2;
      2'h2:    bpd_max = 4'h3;
      default: bpd_max = 4'hC;
    endcase
  end

  // Fractional clock insertion: frame slot below the fine value stretches one source cycle.
  assign pd_done = (prescale_divisor == 3'h0) ? src_tick :
                   (src_tick && pd_cnt == {1'b0, prescale_divisor} + {3'h0, insert});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_cnt <= 4'h0;
      frame  <= 5'h00;
      insert <= 1'b0;
    end else if (src_tick) begin
      if (pd_done) begin
        pd_cnt <= 4'h0;
        frame  <= frame + 5'h01;
        insert <= (prescale_divisor != 3'h0) && ((frame + 5'h01) < prescale_fine_adjust);
      end else begin
        pd_cnt <= pd_cnt + 4'h1;
      end
    end
  end

  assign pre_tick = pd_done;

  // Divide by 64, then the register prescaler, then the baud divisor.
  // The prescaler and divisor end tests use >= so that a smaller divisor written mid-count ends the
  // current period at once instead of running the counter round its full range.
  assign os_tick  = pre_tick && (os_cnt == 6'(SBAT_OVERSAMPLE - 1));
  assign bpd_tick = os_tick && (bpd_cnt >= bpd_max);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      os_cnt    <= 6'h00;
      bpd_cnt   <= 4'h0;
      bd_cnt    <= 8'h00;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (pre_tick) os_cnt <= os_cnt + 6'h01;
      if (os_tick) bpd_cnt <= (bpd_cnt >= bpd_max) ? 4'h0 : bpd_cnt + 4'h1;
      if (bpd_tick) begin
        if (bd_cnt >= (8'h01 << baud_divisor) - 8'h01) begin
          bd_cnt    <= 8'h00;
          baud_tick <= 1'b1;
        end else begin
          bd_cnt <= bd_cnt + 8'h01;
        end
      end
    end
  end

endmodule

/* File: rtl/sbat_pkg.sv */
package sbat_pkg;

  // Register offsets on the plain register port.
  localparam logic [1:0] SBAT_ADDR_CTRL  = 2'h0;
  localparam logic [1:0] SBAT_ADDR_DATA  = 2'h1;
  localparam logic [1:0] SBAT_ADDR_BAUD  = 2'h2;
  localparam logic [1:0] SBAT_ADDR_PRE   = 2'h3;
  localparam logic [2:0] SBAT_ADDR_IRQST = 3'h4;
  localparam logic [2:0] SBAT_ADDR_IRQEN = 3'h5;
  localparam logic [2:0] SBAT_ADDR_IRQCL = 3'h6;

  // Control register field positions.
  localparam int SBAT_BIT_AM_LO = 0;
  localparam int SBAT_BIT_AM_HI = 1;
  localparam int SBAT_BIT_LOST  = 2;
  localparam int SBAT_BIT_CLKS  = 3;
  localparam int SBAT_BIT_FIN   = 4;
  localparam int SBAT_BIT_RUN   = 5;
  localparam int SBAT_BIT_OVF   = 6;
  localparam int SBAT_BIT_MSB   = 7;

  // Baud config field position: source select; prescale and divisor select sit at bits 4:3 and 2:0.
  localparam int SBAT_BIT_SRC   = 7;

  // Interrupt status bits.
  localparam int SBAT_IRQ_LOST  = 0;
  localparam int SBAT_IRQ_FIN   = 1;
  localparam int SBAT_IRQ_OVF   = 2;

  // Counter and sampling constants.
  localparam int          SBAT_CNT_W      = 9;
  localparam logic [8:0]  SBAT_SAMPLE_Q   = 9'h038;
  localparam logic [8:0]  SBAT_SAMPLE_P   = 9'h008;
  localparam logic [1:0]  SBAT_QUARTER    = 2'h3;
  localparam int          SBAT_OVERSAMPLE = 64;
  localparam logic [7:0]  SBAT_RST_BYTE   = 8'h00;

  typedef enum logic [1:0] {
    SBAT_MODE_IDLE,
    SBAT_MODE_MEAS,
    SBAT_MODE_ARB,
    SBAT_MODE_RSVD
  } sbat_mode_t;

  typedef enum {
    SBAT_ST_WAIT,
    SBAT_ST_RUN,
    SBAT_ST_STOP
  } sbat_state_t;

  // Register read and write request as one carrier.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sbat_req_t;

endpackage

/* File: rtl/sbat_rx_sync.sv */
`timescale 1ns/100ps
module sbat_rx_sync
  import sbat_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rx_pin,
  output logic      rx_sync
);

  logic meta;

  // Two flops; the first is read only by the second to contain metastability.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta    <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      meta    <= rx_pin;
      rx_sync <= meta;
    end
  end

endmodule

/* File: testbench/sbat_bus_node.sv */
`timescale 1ns/100ps
module sbat_bus_node (
  input  wire logic tx_pin,
  input  wire logic dominant,
  output logic      rx_pin
);
  // Wired-AND bus line with a pull-up: any node pulling low wins, so the
  // receive level is never a stale copy of a released driver.
  assign rx_pin = tx_pin & ~dominant;
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import sbat_pkg::*;
  logic       clk          = 1'b0;
  logic       sys_rst      = 1'b1;
  logic       quad_tick    = 1'b0;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic       tx_shift_out = 1'b1;
  logic       dominant     = 1'b0;
  logic [2:0] reg_addr     = 3'h0;
  logic [7:0] reg_wdata    = 8'h00;
  logic [7:0] reg_rdata;
  logic       rx_pin;
  logic       tx_pin;
  logic       baud_tick;
  logic       irq;
  logic [7:0] rv;
  logic [8:0] c1;
  logic [8:0] c2;
  int         n_errors     = 0;
  int         check_count  = 0;
  int         gap;
  localparam logic [2:0] CTRL = {1'b0, SBAT_ADDR_CTRL};
  localparam logic [2:0] DATA = {1'b0, SBAT_ADDR_DATA};

  sbat_arbiter sbat_arbiter_inst (.clk(clk), .sys_rst(sys_rst), .quad_tick(quad_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_shift_out(tx_shift_out), .tx_pin(tx_pin),
    .baud_tick(baud_tick), .irq(irq));
  sbat_bus_node sbat_bus_node_inst (.tx_pin(tx_pin), .dominant(dominant), .rx_pin(rx_pin));

  // Clock and a four-times source enable that fires every second cycle.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    quad_tick <= ~quad_tick;
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken at its closing edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic rd_cnt(output logic [8:0] c);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(CTRL, hi);
    rd(DATA, lo);
    c = {hi[7], lo};
  endtask

  // Cycles between two baud pulses; a pulse that never comes ends the run.
  task automatic tick_gap(output int n);
    int k;
    n = 0;
    for (k = 0; k < 4000 && baud_tick !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
    for (n = 1; n < 4000 && baud_tick !== 1'b1; n++) @(posedge clk);
    if (k >= 4000 || n >= 4000) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic t_reset;
    rd(CTRL, rv);
    check("ctrl_reset", rv, 8'h00);
    rd(DATA, rv);
    check("data_reset", rv, 8'h00);
    rd(3'h7, rv);
    check("unmapped", rv, 8'h00);
    check("irq_reset", irq, 1'b0);
    check("tx_reset", tx_pin, 1'b1);
  endtask

  // Falling edge to falling edge 400 cycles apart gives about 100 quarter ticks.
  task automatic t_meas0;
    wr(CTRL, 8'h01);
    cyc(10);
    dominant <= 1'b1;
    cyc(200);
    dominant <= 1'b0;
    cyc(200);
    dominant <= 1'b1;
    cyc(20);
    dominant <= 1'b0;
    rd_cnt(c1);
    check("count_window", c1 >= 9'h062 && c1 <= 9'h066, 1'b1);
    rd(CTRL, rv);
    check("fin_run", rv[6:4], 3'b001);
    cyc(100);
    rd_cnt(c2);
    check("count_held", c2, c1);
    wr(SBAT_ADDR_IRQEN, 8'h02);
    cyc(2);
    check("irq_fin", irq, 1'b1);
    rd(SBAT_ADDR_IRQST, rv);
    check("irq_status", rv[2:0], 3'b010);
    wr(CTRL, 8'h01);
    rd_cnt(c1);
    check("count_cleared", c1, 9'h000);
    rd(CTRL, rv);
    check("fin_cleared", rv[4], 1'b0);
    wr(SBAT_ADDR_IRQCL, 8'h02);
    cyc(2);
    check("irq_cleared", irq, 1'b0);
  endtask

  task automatic t_idle;
    wr(CTRL, 8'h00);
    dominant <= 1'b1;
    cyc(100);
    dominant <= 1'b0;
    cyc(10);
    rd_cnt(c1);
    check("idle_count", c1, 9'h000);
    rd(CTRL, rv);
    check("idle_run", rv[5], 1'b0);
  endtask

  // 2200 cycles of quarter ticks pass 0x1FF once and keep counting.
  task automatic t_ovf;
    wr(CTRL, 8'h01);
    cyc(5);
    dominant <= 1'b1;
    cyc(2200);
    rd(CTRL, rv);
    check("ovf_run", rv[6:5], 2'b11);
    rd_cnt(c1);
    check("wrap_count", c1 >= 9'h022 && c1 <= 9'h028, 1'b1);
    wr(CTRL, 8'h01);
    rd(CTRL, rv);
    check("ovf_cleared", rv[6], 1'b0);
    dominant <= 1'b0;
  endtask

  // Own low before the sample point must reset the count, although the bus then reads low.
  task automatic t_arb;
    tx_shift_out <= 1'b0;
    wr(CTRL, 8'h02);
    wr(SBAT_ADDR_IRQEN, 8'h01);
    tx_shift_out <= 1'b1;
    cyc(100);
    tx_shift_out <= 1'b0;
    cyc(300);
    rd(CTRL, rv);
    check("own_low_no_loss", rv[2], 1'b0);
    rd_cnt(c1);
    check("own_low_reset", c1, 9'h000);
    check("tx_follows", tx_pin, 1'b0);
    tx_shift_out <= 1'b1;
    cyc(146);
    rd_cnt(c1);
    check("arb_count", c1 >= 9'h023 && c1 <= 9'h027, 1'b1);
    dominant <= 1'b1;
    cyc(150);
    dominant <= 1'b0;
    cyc(5);
    rd(CTRL, rv);
    check("lost_set", rv[2], 1'b1);
    tx_shift_out <= 1'b0;
    cyc(3);
    check("tx_forced", tx_pin, 1'b1);
    check("irq_lost", irq, 1'b1);
    wr(CTRL, 8'h02);
    rd(CTRL, rv);
    check("lost_kept", rv[2], 1'b1);
    wr(CTRL, 8'h00);
    rd(CTRL, rv);
    check("lost_cleared", rv[2], 1'b0);
    check("tx_released", tx_pin, 1'b0);
    wr(SBAT_ADDR_IRQCL, 8'h01);
    cyc(2);
    check("irq_lost_clr", irq, 1'b0);
    tx_shift_out <= 1'b1;
  endtask

  // Receive already low when measurement is enabled: counting starts at once.
  task automatic t_meas1;
    dominant <= 1'b1;
    cyc(5);
    wr(CTRL, 8'h09);
    cyc(300);
    rd(CTRL, rv);
    check("break_running", rv[5:4], 2'b10);
    dominant <= 1'b0;
    cyc(10);
    rd(CTRL, rv);
    check("break_done", rv[5:4], 2'b01);
    rd_cnt(c1);
    check("break_count", c1 >= 9'h096 && c1 <= 9'h09A, 1'b1);
    cyc(50);
    rd_cnt(c2);
    check("break_held", c2, c1);
  endtask

  // Period is 64 * REG_PRESCALE_DIV * BD * (PD + fine) source cycles; the last two use the prescaler,
  // and with half a cycle of fine adjust every period spans exactly two 32-slot frames, 32 of whose slots insert a cycle.
  task automatic t_baud;
    logic [7:0] cfg [6] = '{8'h00, 8'h08, 8'h01, 8'h80, 8'h00, 8'h00};
    logic [7:0] pre [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, 8'hF0};
    int         exp [6] = '{64, 192, 128, 128, 512, 544};
    for (int i = 0; i < 6; i++) begin
      wr({1'b0, SBAT_ADDR_BAUD}, cfg[i]);
      wr({1'b0, SBAT_ADDR_PRE}, pre[i]);
      tick_gap(gap);
      tick_gap(gap);
      check("baud_period", gap, exp[i]);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_meas0();
    t_idle();
    t_ovf();
    t_arb();
    t_meas1();
    t_baud();
    give_verdict();
  end
endmodule
